// file: sio_pkg.sv
// Constants and types for the servo sequence I/O and status block
// ---------------------------------------------------------------
// Overview of operation
// (R1) Both travel prohibits are off after reset; a control bit enables each direction.
// (R2) A prohibited direction raises a stop request carrying the selected stop method.
// (R3) A travel prohibit never touches the fault output.
// (R4) Position loop is held while a prohibit stop runs in position mode.
// (R5) In torque mode the primary stop method is used; the limit method is ignored.
// (R6) Homing: decel switch high selects approach speed 1, falling selects latch operation.
// (R7) Each rising edge of a latch input captures the feedback pulse counter into its own register.
// (R8) Any detected error drives the fault output OFF.
// (R9) Fault output is OFF after power-up until initial processing completes.
// (R10) Done 1/2 are ON when the deviation magnitude is below range 1/2.
// (R11) Both done outputs are OFF outside position control.
// (R12) Speed match is ON when command and motor speed differ by at most the range.
// (R13) Speed match is OFF outside speed control.
// (R14) Motion detect is ON when motor speed magnitude exceeds the detect speed.
// (R15) Motion detect is held ON while no encoder is connected.
// (R16) Servo ready is ON only with main power up and no error detected.
// (R17) Input functions and output terminals follow map registers, defaulting to the standard map.
// (R18) By default done, speed match, motion detect and ready drive no terminal.
// (R19) Brake hold timing uses brake delay 1, brake command speed and brake delay 2.
// (R20) Inputs are synchronised and debounced; latches capture on the filtered rising edge.
// (R21) All status outputs are registered and inactive during reset.
// ---------------------------------------------------------------
package sio_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL        = 8'h00;
  localparam logic [7:0] ADR_INPUT_MAP   = 8'h04;
  localparam logic [7:0] ADR_OUTPUT_MAP  = 8'h08;
  localparam logic [7:0] ADR_DONE_RANGE1 = 8'h0C;
  localparam logic [7:0] ADR_DONE_RANGE2 = 8'h10;
  localparam logic [7:0] ADR_MATCH_RANGE = 8'h14;
  localparam logic [7:0] ADR_DETECT_SPD  = 8'h18;
  localparam logic [7:0] ADR_BRAKE_DLY1  = 8'h1C;
  localparam logic [7:0] ADR_BRAKE_SPD   = 8'h20;
  localparam logic [7:0] ADR_BRAKE_DLY2  = 8'h24;
  localparam logic [7:0] ADR_HOME_SPD1   = 8'h28;
  localparam logic [7:0] ADR_STATUS      = 8'h2C;
  localparam logic [7:0] ADR_LATCH1      = 8'h30;
  localparam logic [7:0] ADR_LATCH2      = 8'h34;
  localparam logic [7:0] ADR_LATCH3      = 8'h38;

  // CTRL fields
  localparam int CTRL_FWD_EN   = 0;
  localparam int CTRL_REV_EN   = 1;
  localparam int CTRL_STOP_PRI = 2;  // 2 bits
  localparam int CTRL_STOP_LIM = 4;  // 2 bits
  localparam int CTRL_HOME     = 6;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;

  // Input map: six 4-bit fields, bit 3 = connected, bits 2:0 = terminal SI0..SI6
  localparam int IMAP_FWD = 0;
  localparam int IMAP_REV = 1;
  localparam int IMAP_DEC = 2;
  localparam int IMAP_LT1 = 3;
  localparam int IMAP_LT2 = 4;
  localparam int IMAP_LT3 = 5;
  localparam logic [31:0] RST_INPUT_MAP = 32'h00ED_CBA9;

  // Output map: one 4-bit function code per terminal SO1..SO3
  localparam logic [3:0] FN_NONE   = 4'h0;
  localparam logic [3:0] FN_DONE1  = 4'h1;
  localparam logic [3:0] FN_DONE2  = 4'h2;
  localparam logic [3:0] FN_MATCH  = 4'h3;
  localparam logic [3:0] FN_MOTION = 4'h4;
  localparam logic [3:0] FN_READY  = 4'h5;
  localparam logic [3:0] FN_BRAKE  = 4'h6;
  localparam logic [31:0] RST_OUTPUT_MAP = 32'h0000_0006;
  localparam logic [31:0] RST_SETTING    = 32'h0000_0000;

  // Control modes reported by the drive core
  localparam logic [1:0] MODE_POSITION = 2'h0;
  localparam logic [1:0] MODE_SPEED    = 2'h1;
  localparam logic [1:0] MODE_TORQUE   = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ       = 10_000_000;
  localparam int DEBOUNCE_US  = 10;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int BRAKE_TICK_MS  = 1;
  localparam int BRAKE_TICK_CYC = BRAKE_TICK_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    HOME_IDLE = 2'b00, HOME_SEEK = 2'b01, HOME_APPROACH = 2'b11, HOME_LATCH = 2'b10
  } sioHome_t;

  typedef enum logic [1:0] {
    BRK_RELEASED = 2'b00, BRK_DELAY1 = 2'b01, BRK_WAIT2 = 2'b11, BRK_ENGAGED = 2'b10
  } sioBrake_t;

endpackage

// file: sio_servo_io.sv
// Sequence input conditioning, status outputs and register file of the servo drive
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module sio_servo_io #(
  parameter int TICK_CYCLES = sio_pkg::BRAKE_TICK_CYC,
  parameter int DEB_CYCLES  = sio_pkg::DEBOUNCE_CYC
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Sequence terminals SI0..SI6 and output terminals SO1..SO3
  input  wire logic [6:0]  seqIn,
  output logic      [2:0]  seqOut,
  output logic             faultOut,
  // Drive core status
  input  wire logic [1:0]  controlMode,
  input  wire logic        errorDetected,
  input  wire logic        initDone,
  input  wire logic        mainPowerOn,
  input  wire logic        encoderPresent,
  input  wire logic        servoOn,
  input  wire logic [31:0] deviationCount,
  input  wire logic [31:0] speedCmd,
  input  wire logic [31:0] motorSpeed,
  input  wire logic [31:0] feedbackCount,
  // Drive core commands
  output logic             stopRequest,
  output logic      [1:0]  stopMethod,
  output logic             posLoopHold,
  output logic             homeApproach,
  output logic      [31:0] homeSpeedCmd,
  output logic             homeLatchMode
);

  localparam int DBW = $clog2(DEB_CYCLES + 1);
  localparam int TKW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [6:0]            sync1;
    logic [6:0]            sync2;
    logic [6:0][DBW-1:0]   debCnt;
    logic [6:0]            filt;
    logic [31:0]           ctrl;
    logic [31:0]           inMap;
    logic [31:0]           outMap;
    logic [31:0]           range1;
    logic [31:0]           range2;
    logic [31:0]           matchRange;
    logic [31:0]           detectSpd;
    logic [31:0]           brakeDly1;
    logic [31:0]           brakeSpd;
    logic [31:0]           brakeDly2;
    logic [31:0]           homeSpd1;
    logic [2:0][31:0]      latchVal;
    logic [2:0]            latchHit;
    sio_pkg::sioHome_t     home;
    sio_pkg::sioBrake_t    brake;
    logic [TKW-1:0]        tickCnt;
    logic [31:0]           brakeTicks;
    logic                  done1;
    logic                  done2;
    logic                  match;
    logic                  motion;
    logic                  ready;
    logic                  brakeHold;
    logic [2:0]            seqOut;
    logic                  faultOut;
    logic                  stopReq;
    logic [1:0]            stopMethod;
    logic                  posHold;
    logic                  homeApproach;
    logic [31:0]           homeSpeedCmd;
    logic                  homeLatch;
    logic                  ack;
    logic [31:0]           rdata;
  } sioState_t;

  sioState_t q;
  sioState_t d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] absVal(input logic [31:0] v);
    absVal = v[31] ? 32'(-v) : v;
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    byteMerge = r;
  endfunction

  // An unconnected function reads as inactive
  function automatic logic pickIn(input logic [31:0] map, input int fn,
                                  input logic [6:0] pins);
    logic [3:0] f;
    f = map[4*fn +: 4];
    pickIn = (f[3] && f[2:0] != 3'h7) ? pins[f[2:0]] : 1'b0;
  endfunction

  function automatic logic pickOut(input logic [3:0] code, input sioState_t s);
    case (code)
      sio_pkg::FN_DONE1:  pickOut = s.done1;
      sio_pkg::FN_DONE2:  pickOut = s.done2;
      sio_pkg::FN_MATCH:  pickOut = s.match;
      sio_pkg::FN_MOTION: pickOut = s.motion;
      sio_pkg::FN_READY:  pickOut = s.ready;
      sio_pkg::FN_BRAKE:  pickOut = s.brakeHold;
      default:            pickOut = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic        fwdAllowed;
  logic        revAllowed;
  logic        decelIn;
  logic [2:0]  latchIn;
  logic [2:0]  latchRise;
  logic        fwdBlock;
  logic        revBlock;
  logic        access;
  logic        wr;
  logic [31:0] spdAbs;
  logic        tick;
  logic        slowNow;

  always_comb begin
    d = q;
    // Synchroniser, then a stable-for-N-cycles filter per terminal
    d.sync1 = seqIn;
    d.sync2 = q.sync1;
    for (int i = 0; i < 7; i++) begin
      if (q.sync2[i] == q.filt[i]) begin
        d.debCnt[i] = '0;
      end else if (q.debCnt[i] == DBW'(DEB_CYCLES - 1)) begin
        d.debCnt[i] = '0;
        d.filt[i]   = q.sync2[i];  // (R20)
      end else begin
        d.debCnt[i] = q.debCnt[i] + DBW'(1);
      end
    end

    // Input function routing
    fwdAllowed = pickIn(q.inMap, sio_pkg::IMAP_FWD, q.filt);  // (R17)
    revAllowed = pickIn(q.inMap, sio_pkg::IMAP_REV, q.filt);
    decelIn    = pickIn(q.inMap, sio_pkg::IMAP_DEC, q.filt);
    latchIn[0] = pickIn(q.inMap, sio_pkg::IMAP_LT1, q.filt);
    latchIn[1] = pickIn(q.inMap, sio_pkg::IMAP_LT2, q.filt);
    latchIn[2] = pickIn(q.inMap, sio_pkg::IMAP_LT3, q.filt);
    latchRise  = '0;
    // Edge of the filtered level: new filter value high, old one low
    for (int i = 0; i < 3; i++) begin
      latchRise[i] = pickIn(q.inMap, sio_pkg::IMAP_LT1 + i, d.filt) & ~latchIn[i];  // (R20)
      if (latchRise[i]) begin
        d.latchVal[i] = feedbackCount;  // (R7)
        d.latchHit[i] = 1'b1;
      end
    end

    // Travel prohibit: terminal ON means travel allowed
    fwdBlock = q.ctrl[sio_pkg::CTRL_FWD_EN] & ~fwdAllowed;  // (R1)
    revBlock = q.ctrl[sio_pkg::CTRL_REV_EN] & ~revAllowed;  // (R1)
    d.stopReq = (fwdBlock & ~speedCmd[31] & (speedCmd != 32'h0000_0000)) |
                (revBlock & speedCmd[31]);  // (R2)
    if (controlMode == sio_pkg::MODE_TORQUE) begin
      d.stopMethod = q.ctrl[sio_pkg::CTRL_STOP_PRI +: 2];  // (R5)
    end else begin
      d.stopMethod = q.ctrl[sio_pkg::CTRL_STOP_LIM +: 2];  // (R2)
    end
    d.posHold = d.stopReq & (controlMode == sio_pkg::MODE_POSITION);  // (R4)

    // Fault output depends on init and errors only, never on a prohibit
    d.faultOut = initDone & ~errorDetected;  // (R3) (R8) (R9)

    // Status functions
    spdAbs  = absVal(motorSpeed);
    d.done1 = (controlMode == sio_pkg::MODE_POSITION) &&
              (absVal(deviationCount) < q.range1);  // (R10) (R11)
    d.done2 = (controlMode == sio_pkg::MODE_POSITION) &&
              (absVal(deviationCount) < q.range2);  // (R10) (R11)
    d.match = (controlMode == sio_pkg::MODE_SPEED) &&
              (absVal(32'(speedCmd - motorSpeed)) <= q.matchRange);  // (R12) (R13)
    d.motion = ~encoderPresent | (spdAbs > q.detectSpd);  // (R14) (R15)
    d.ready  = mainPowerOn & ~errorDetected;  // (R16)

    // Homing sequence
    case (q.home)
      sio_pkg::HOME_IDLE: begin
        if (q.ctrl[sio_pkg::CTRL_HOME]) begin
          d.home = sio_pkg::HOME_SEEK;
        end
      end
      sio_pkg::HOME_SEEK: begin
        if (decelIn) begin
          d.home = sio_pkg::HOME_APPROACH;  // (R6)
        end
      end
      sio_pkg::HOME_APPROACH: begin
        if (!decelIn) begin
          d.home = sio_pkg::HOME_LATCH;  // (R6)
        end
      end
      sio_pkg::HOME_LATCH: begin
        d.home = sio_pkg::HOME_LATCH;
      end
      default: begin
        d.home = sio_pkg::HOME_IDLE;
      end
    endcase
    if (!q.ctrl[sio_pkg::CTRL_HOME]) begin
      d.home = sio_pkg::HOME_IDLE;
    end
    d.homeApproach = (d.home == sio_pkg::HOME_APPROACH);  // (R6)
    d.homeSpeedCmd = d.homeApproach ? q.homeSpd1 : 32'h0000_0000;
    d.homeLatch    = (d.home == sio_pkg::HOME_LATCH);

    // Brake timing, counted in ticks
    tick      = (q.tickCnt == TKW'(TICK_CYCLES - 1));
    d.tickCnt = tick ? '0 : q.tickCnt + TKW'(1);
    slowNow   = spdAbs < q.brakeSpd;
    case (q.brake)
      sio_pkg::BRK_RELEASED: begin
        d.brakeTicks = 32'h0000_0000;
        if (!servoOn) begin
          d.brake = slowNow ? sio_pkg::BRK_DELAY1 : sio_pkg::BRK_WAIT2;  // (R19)
          d.tickCnt = '0;
        end
      end
      sio_pkg::BRK_DELAY1: begin
        // Stopped motor: brake output stays released through delay 1, then the brake engages
        if (tick) begin
          d.brakeTicks = q.brakeTicks + 32'h0000_0001;
        end
        if (q.brakeTicks >= q.brakeDly1) begin
          d.brake = sio_pkg::BRK_ENGAGED;  // (R19)
        end
      end
      sio_pkg::BRK_WAIT2: begin
        // Moving motor: brake output drops at once; state goes to engaged at command speed or after delay 2
        if (tick) begin
          d.brakeTicks = q.brakeTicks + 32'h0000_0001;
        end
        if (slowNow || (q.brakeTicks >= q.brakeDly2)) begin
          d.brake = sio_pkg::BRK_ENGAGED;  // (R19)
        end
      end
      sio_pkg::BRK_ENGAGED: begin
        d.brakeTicks = 32'h0000_0000;
        if (servoOn) begin
          d.brake = sio_pkg::BRK_RELEASED;
        end
      end
      default: begin
        d.brake = sio_pkg::BRK_ENGAGED;
      end
    endcase
    if (servoOn && q.brake != sio_pkg::BRK_RELEASED) begin
      d.brake = sio_pkg::BRK_RELEASED;
    end
    d.brakeHold = (d.brake == sio_pkg::BRK_RELEASED) || (d.brake == sio_pkg::BRK_DELAY1);

    // Output terminal routing from the freshly computed functions
    for (int i = 0; i < 3; i++) begin
      d.seqOut[i] = pickOut(q.outMap[4*i +: 4], d);  // (R17) (R18)
    end

    // Wishbone: one wait state, ack for exactly one cycle
    access = wb_cyc_i & wb_stb_i & ~q.ack;
    wr     = access & wb_we_i;
    d.ack  = access;
    d.rdata = 32'h0000_0000;
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        sio_pkg::ADR_CTRL:        d.rdata = q.ctrl;
        sio_pkg::ADR_INPUT_MAP:   d.rdata = q.inMap;
        sio_pkg::ADR_OUTPUT_MAP:  d.rdata = q.outMap;
        sio_pkg::ADR_DONE_RANGE1: d.rdata = q.range1;
        sio_pkg::ADR_DONE_RANGE2: d.rdata = q.range2;
        sio_pkg::ADR_MATCH_RANGE: d.rdata = q.matchRange;
        sio_pkg::ADR_DETECT_SPD:  d.rdata = q.detectSpd;
        sio_pkg::ADR_BRAKE_DLY1:  d.rdata = q.brakeDly1;
        sio_pkg::ADR_BRAKE_SPD:   d.rdata = q.brakeSpd;
        sio_pkg::ADR_BRAKE_DLY2:  d.rdata = q.brakeDly2;
        sio_pkg::ADR_HOME_SPD1:   d.rdata = q.homeSpd1;
        sio_pkg::ADR_STATUS: begin
          d.rdata = {7'h00, q.latchHit, q.brake, q.home, q.seqOut, q.faultOut,
                     q.brakeHold, q.ready, q.motion, q.match, q.done2, q.done1,
                     q.stopReq, q.filt};
        end
        sio_pkg::ADR_LATCH1:      d.rdata = q.latchVal[0];
        sio_pkg::ADR_LATCH2:      d.rdata = q.latchVal[1];
        sio_pkg::ADR_LATCH3:      d.rdata = q.latchVal[2];
        default:                  d.rdata = 32'h0000_0000;
      endcase
      // Reading a latch clears its hit flag, unless a new capture lands now
      for (int i = 0; i < 3; i++) begin
        if (wb_adr_i == 8'(sio_pkg::ADR_LATCH1 + 8'(4 * i)) && !latchRise[i]) begin
          d.latchHit[i] = 1'b0;
        end
      end
    end
    if (wr) begin
      case (wb_adr_i)
        sio_pkg::ADR_CTRL:        d.ctrl       = byteMerge(q.ctrl, wb_dat_i, wb_sel_i) &
                                                 32'h0000_007F;
        sio_pkg::ADR_INPUT_MAP:   d.inMap      = byteMerge(q.inMap, wb_dat_i, wb_sel_i) &
                                                 32'h00FF_FFFF;
        sio_pkg::ADR_OUTPUT_MAP:  d.outMap     = byteMerge(q.outMap, wb_dat_i, wb_sel_i) &
                                                 32'h0000_0FFF;
        sio_pkg::ADR_DONE_RANGE1: d.range1     = byteMerge(q.range1, wb_dat_i, wb_sel_i);
        sio_pkg::ADR_DONE_RANGE2: d.range2     = byteMerge(q.range2, wb_dat_i, wb_sel_i);
        sio_pkg::ADR_MATCH_RANGE: d.matchRange = byteMerge(q.matchRange, wb_dat_i, wb_sel_i);
        sio_pkg::ADR_DETECT_SPD:  d.detectSpd  = byteMerge(q.detectSpd, wb_dat_i, wb_sel_i);
        sio_pkg::ADR_BRAKE_DLY1:  d.brakeDly1  = byteMerge(q.brakeDly1, wb_dat_i, wb_sel_i);
        sio_pkg::ADR_BRAKE_SPD:   d.brakeSpd   = byteMerge(q.brakeSpd, wb_dat_i, wb_sel_i);
        sio_pkg::ADR_BRAKE_DLY2:  d.brakeDly2  = byteMerge(q.brakeDly2, wb_dat_i, wb_sel_i);
        sio_pkg::ADR_HOME_SPD1:   d.homeSpd1   = byteMerge(q.homeSpd1, wb_dat_i, wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q            <= '0;  // (R21)
      q.ctrl       <= sio_pkg::RST_CTRL;  // (R1)
      q.inMap      <= sio_pkg::RST_INPUT_MAP;  // (R17)
      q.outMap     <= sio_pkg::RST_OUTPUT_MAP;  // (R18)
      q.range1     <= sio_pkg::RST_SETTING;
      q.range2     <= sio_pkg::RST_SETTING;
      q.matchRange <= sio_pkg::RST_SETTING;
      q.detectSpd  <= sio_pkg::RST_SETTING;
      q.brakeDly1  <= sio_pkg::RST_SETTING;
      q.brakeSpd   <= sio_pkg::RST_SETTING;
      q.brakeDly2  <= sio_pkg::RST_SETTING;
      q.homeSpd1   <= sio_pkg::RST_SETTING;
      q.home       <= sio_pkg::HOME_IDLE;
      q.brake      <= sio_pkg::BRK_ENGAGED;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all taken straight from the state register
  // ---------------------------------------------------------------
  assign wb_dat_o      = q.rdata;
  assign wb_ack_o      = q.ack;
  assign seqOut        = q.seqOut;  // (R21)
  assign faultOut      = q.faultOut;
  assign stopRequest   = q.stopReq;
  assign stopMethod    = q.stopMethod;
  assign posLoopHold   = q.posHold;
  assign homeApproach  = q.homeApproach;
  assign homeSpeedCmd  = q.homeSpeedCmd;
  assign homeLatchMode = q.homeLatch;

endmodule
`default_nettype wire

// file: sio_servo_io_sva.sv
// Concurrent checks on the servo sequence I/O block ports
`timescale 1ns/1ns
`default_nettype none
module sio_servo_io_sva (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [2:0]  seqOut,
  input wire logic        faultOut,
  input wire logic [1:0]  controlMode,
  input wire logic        errorDetected,
  input wire logic        initDone,
  input wire logic [31:0] speedCmd,
  input wire logic        stopRequest,
  input wire logic        posLoopHold,
  input wire logic        homeApproach,
  input wire logic [31:0] homeSpeedCmd,
  input wire logic        homeLatchMode
);
  // --------
  // Checks
  // --------
  default clocking cb @(posedge clock); endclocking
  property p_fault;
    disable iff (!resetn) $past(resetn) |-> faultOut == ($past(initDone) && !$past(errorDetected));
  endproperty
  a_fault: assert property (p_fault) else $error("fault output mismatch");
  property p_hold;
    disable iff (!resetn) $past(resetn) |->
      posLoopHold == (stopRequest && $past(controlMode) == sio_pkg::MODE_POSITION);
  endproperty
  a_hold: assert property (p_hold) else $error("position loop hold mismatch");
  property p_stop;
    disable iff (!resetn) stopRequest |-> $past(speedCmd) != 32'h0000_0000;
  endproperty
  a_stop: assert property (p_stop) else $error("stop without commanded travel");
  property p_home_excl;
    disable iff (!resetn) homeApproach |-> !homeLatchMode;
  endproperty
  a_home_excl: assert property (p_home_excl) else $error("approach and latch together");
  property p_home_spd;
    disable iff (!resetn) !homeApproach |-> homeSpeedCmd == 32'h0000_0000;
  endproperty
  a_home_spd: assert property (p_home_spd) else $error("homing speed outside approach");
  property p_latch_seq;
    disable iff (!resetn) $rose(homeLatchMode) |-> $past(homeApproach);
  endproperty
  a_latch_seq: assert property (p_latch_seq) else $error("latch mode without approach");
  // Reset itself is the condition here, so nothing disables it
  property p_reset;
    !resetn |-> !faultOut && seqOut == 3'h0 && !wb_ack_o && !stopRequest && !homeApproach;
  endproperty
  a_reset: assert property (p_reset) else $error("output active in reset");
  property p_ack;
    disable iff (!resetn) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_req;
    disable iff (!resetn) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_req: assert property (p_req) else $error("request not acknowledged");
endmodule
bind sio_servo_io sio_servo_io_sva u_sva (.*);
`default_nettype wire

// file: sio_machine_model.sv
// Machine-side model: travel limits, homing switch and latch sensors
`timescale 1ns/1ns
`default_nettype none
module sio_machine_model (
  input  wire logic signed [31:0] axisPos,
  input  wire logic               clock,
  input  wire logic [2:0]         latchTrig,
  output logic [6:0]              seqIn = 7'h00
);
  // --------
  // Sensors on the default terminals
  // --------
  // Limit inputs read ON inside the stroke, so a broken wire stops travel
  always_ff @(posedge clock) begin
    seqIn[0] <= 1'h0;
    seqIn[1] <= axisPos < 1000;
    seqIn[2] <= axisPos > -1000;
    seqIn[3] <= axisPos > 400 && axisPos < 500;
    seqIn[6:4] <= latchTrig;
  end
endmodule
`default_nettype wire

// file: sio_testbench.sv
// Self-checking testbench for the servo sequence I/O block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clock = 1'h0, resetn, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic        errorDetected = 1'h0, initDone = 1'h0, mainPowerOn = 1'h0, servoOn = 1'h0;
  logic        encoderPresent = 1'h1;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [1:0]  controlMode = 2'h0;
  logic [31:0] wb_dat_i = '0, deviationCount = '0, speedCmd = '0, motorSpeed = '0;
  logic [31:0] feedbackCount = '0, wb_dat_o, homeSpeedCmd, rd;
  logic signed [31:0] axisPos = '0;
  logic [2:0]  latchTrig = 3'h0, seqOut;
  logic [6:0]  seqIn;
  logic [1:0]  stopMethod;
  logic        wb_ack_o, faultOut, stopRequest, posLoopHold, homeApproach, homeLatchMode;
  int          errors = 0, tests_run = 0, cycles = 0;
  sio_servo_io #(.TICK_CYCLES(4), .DEB_CYCLES(2)) dut (.*);
  sio_machine_model model (.clock(clock), .axisPos(axisPos), .latchTrig(latchTrig), .seqIn(seqIn));
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  // --------
  // Tasks
  // --------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Holds the request until ack is seen at an edge, then releases it
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clock);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clock); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic settle();
    repeat (8) @(posedge clock);
  endtask
  task automatic stat(input logic [1:0] m, input logic [31:0] dev, mot, input logic [2:0] e);
    controlMode <= m;
    deviationCount <= dev;
    motorSpeed <= mot;
    settle();
    chk(32'(seqOut), 32'(e));
  endtask
  // --------
  // Sequence
  // --------
  initial begin
    resetn <= 1'h0;
    repeat (10) @(posedge clock);
    resetn <= 1'h1;
    wb(1'h0, sio_pkg::ADR_CTRL, '0);
    chk(rd, 32'h0000_0000);
    wb(1'h0, sio_pkg::ADR_INPUT_MAP, '0);
    chk(rd, 32'h00ED_CBA9);
    wb(1'h0, sio_pkg::ADR_OUTPUT_MAP, '0);
    chk(rd, 32'h0000_0006);
    wb(1'h1, 8'h3C, 32'hFFFF_FFFF);
    wb(1'h0, 8'h3C, '0);
    chk(rd, 32'h0000_0000);
    chk(32'(faultOut), 32'h0000_0000);
    initDone <= 1'h1;
    mainPowerOn <= 1'h1;
    axisPos <= 2000;
    speedCmd <= 32'h0000_0064;
    settle();
    chk(32'({stopRequest, faultOut}), 32'h0000_0001);
    wb(1'h1, sio_pkg::ADR_CTRL, 32'h0000_0025);
    settle();
    chk(32'({stopMethod, posLoopHold, stopRequest, faultOut}), 32'h0000_0017);
    controlMode <= 2'h2;
    settle();
    chk(32'({stopMethod, posLoopHold, stopRequest, faultOut}), 32'h0000_000B);
    speedCmd <= 32'hFFFF_FF9C;
    settle();
    chk(32'(stopRequest), 32'h0000_0000);
    axisPos <= 0;
    speedCmd <= 32'h0000_0064;
    wb(1'h1, sio_pkg::ADR_OUTPUT_MAP, 32'h0000_0321);
    wb(1'h1, sio_pkg::ADR_DONE_RANGE1, 32'h0000_000A);
    wb(1'h1, sio_pkg::ADR_DONE_RANGE2, 32'h0000_0005);
    wb(1'h1, sio_pkg::ADR_MATCH_RANGE, 32'h0000_0005);
    stat(2'h0, 32'h0000_0007, '0, 3'h1);
    stat(2'h0, 32'hFFFF_FFFC, '0, 3'h3);
    stat(2'h0, 32'h0000_0005, '0, 3'h1);
    stat(2'h1, 32'hFFFF_FFFC, 32'h0000_005F, 3'h4);
    stat(2'h1, '0, 32'h0000_005E, 3'h0);
    stat(2'h1, '0, 32'h0000_0069, 3'h4);
    stat(2'h2, '0, 32'h0000_0064, 3'h0);
    wb(1'h1, sio_pkg::ADR_OUTPUT_MAP, 32'h0000_0654);
    wb(1'h1, sio_pkg::ADR_DETECT_SPD, 32'h0000_0032);
    stat(2'h1, '0, 32'h0000_0032, 3'h2);
    stat(2'h1, '0, 32'hFFFF_FFCD, 3'h3);
    encoderPresent <= 1'h0;
    stat(2'h1, '0, '0, 3'h3);
    encoderPresent <= 1'h1;
    errorDetected <= 1'h1;
    stat(2'h1, '0, '0, 3'h0);
    chk(32'(faultOut), 32'h0000_0000);
    errorDetected <= 1'h0;
    wb(1'h1, sio_pkg::ADR_BRAKE_DLY1, 32'h0000_0003);
    wb(1'h1, sio_pkg::ADR_BRAKE_SPD, 32'h0000_0014);
    wb(1'h1, sio_pkg::ADR_BRAKE_DLY2, 32'h0000_0002);
    servoOn <= 1'h1;
    stat(2'h1, '0, '0, 3'h6);
    servoOn <= 1'h0;
    repeat (4) @(posedge clock);
    chk(32'(seqOut[2]), 32'h0000_0001);
    repeat (20) @(posedge clock);
    chk(32'(seqOut[2]), 32'h0000_0000);
    servoOn <= 1'h1;
    stat(2'h1, '0, 32'h0000_01F4, 3'h7);
    servoOn <= 1'h0;
    settle();
    chk(32'(seqOut[2]), 32'h0000_0000);
    wb(1'h1, sio_pkg::ADR_HOME_SPD1, 32'h0000_0123);
    wb(1'h1, sio_pkg::ADR_CTRL, 32'h0000_0065);
    settle();
    chk(32'({homeLatchMode, homeApproach}), 32'h0000_0000);
    axisPos <= 450;
    settle();
    chk(32'({homeLatchMode, homeApproach}), 32'h0000_0001);
    chk(homeSpeedCmd, 32'h0000_0123);
    axisPos <= 600;
    settle();
    chk(32'({homeLatchMode, homeApproach}), 32'h0000_0002);
    for (int i = 0; i < 3; i++) begin
      feedbackCount <= 32'h0000_0100 + i;
      latchTrig <= 3'(1 << i);
      settle();
      latchTrig <= 3'h0;
      feedbackCount <= '0;
      settle();
      wb(1'h0, 8'(sio_pkg::ADR_LATCH1 + 4 * i), '0);
      chk(rd, 32'h0000_0100 + i);
    end
    resetn <= 1'h0;
    settle();
    chk(32'({faultOut, seqOut, stopRequest}), 32'h0000_0000);
    resetn <= 1'h1;
    settle();
    report_and_stop();
  end
endmodule
`default_nettype wire
